// >>> pkg/tmh_pkg.sv
// shared constants and types for the 8-bit compare timer channel
package tmh_pkg;

  // bus geometry
  localparam int          DATA_W     = 32;
  localparam int          ADDR_W     = 28;
  localparam int          REG_W      = 8;

  // register byte addresses
  localparam logic [27:0] OFF_MODE   = 28'hFFFF580;
  localparam logic [27:0] OFF_CMP0   = 28'hFFFF584;
  localparam logic [27:0] OFF_CMP1   = 28'hFFFF588;
  localparam logic [27:0] OFF_CARR   = 28'hFFFF58C;
  localparam logic [27:0] OFF_IRQST  = 28'hFFFF590;
  localparam logic [27:0] OFF_IRQMSK = 28'hFFFF594;
  localparam logic [27:0] OFF_COUNT  = 28'hFFFF598;

  // mode register fields
  localparam int          MODE_EN    = 7;
  localparam int          MODE_CKS_H = 6;
  localparam int          MODE_CKS_L = 4;
  localparam int          MODE_OPM_H = 3;
  localparam int          MODE_OPM_L = 2;
  localparam int          MODE_LEV   = 1;
  localparam int          MODE_OEN   = 0;

  // carrier control register fields
  localparam int          CARR_RMC   = 2;
  localparam int          CARR_NRZB  = 1;
  localparam int          CARR_NRZ   = 0;

  // interrupt status / mask field
  localparam int          IRQ_MATCH  = 0;

  // values after reset
  localparam logic [7:0]  RST_REG    = 8'h00;
  localparam logic [7:0]  CNT_CLEAR  = 8'h00;

  // count clock select codes
  localparam logic [2:0]  CKS_DIV1   = 3'h0;
  localparam logic [2:0]  CKS_DIV2   = 3'h1;
  localparam logic [2:0]  CKS_DIV4   = 3'h2;
  localparam logic [2:0]  CKS_DIV16  = 3'h3;
  localparam logic [2:0]  CKS_DIV64  = 3'h4;
  localparam logic [2:0]  CKS_SLOW   = 3'h5;

  // prescaler width: slowest division is 2**10
  localparam int          DIV_W      = 10;

  // axi response codes
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // operating modes
  typedef enum logic [1:0] {
    TMH_INTERVAL = 2'h0,
    TMH_CARRIER  = 2'h1,
    TMH_PWM      = 2'h2,
    TMH_BADMODE  = 2'h3
  } tmh_mode_t;

endpackage

// >>> pkg/tmh_tick_if.sv
// count-clock request and tick between timer core and prescaler
interface tmh_tick_if;
  logic       en;
  logic [2:0] sel;
  logic       subClock;
  logic       tick;

  modport core      (output en, output sel, output subClock, input tick);
  modport prescaler (input en, input sel, input subClock, output tick);
endinterface

// >>> src/tmh_prescaler.sv
// count clock prescaler and selector for one timer channel
module tmh_prescaler #(
  parameter int CHANNEL = 0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  // tick request
  tmh_tick_if.prescaler tickIf
);
  import tmh_pkg::*;

  logic [DIV_W-1:0] div_q;
  logic             subPrev_q;
  logic             subEdge;

  if (CHANNEL < 0 || CHANNEL > 1) begin : g_chk
    $error("tmh_prescaler: CHANNEL must be 0 or 1");
  end

  // divider held at zero while stopped, so a start counts from a clean phase
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      div_q <= '0;
    end else if (!tickIf.en) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  // subclock is synchronous already; only its rising edge counts
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      subPrev_q <= 1'b0;
    end else begin
      subPrev_q <= tickIf.subClock;
    end
  end

  assign subEdge = tickIf.subClock & ~subPrev_q;

  // tick selection; prohibited codes give no tick at all
  always_comb begin
    unique case (tickIf.sel)
      CKS_DIV1:  tickIf.tick = tickIf.en;
      CKS_DIV2:  tickIf.tick = tickIf.en & div_q[0];
      CKS_DIV4:  tickIf.tick = tickIf.en & (&div_q[1:0]);
      CKS_DIV16: tickIf.tick = tickIf.en & (&div_q[3:0]);
      CKS_DIV64: tickIf.tick = tickIf.en & (&div_q[5:0]);
      CKS_SLOW:  tickIf.tick = tickIf.en & ((CHANNEL == 0) ? (&div_q) : subEdge);
      default:   tickIf.tick = 1'b0;
    endcase
  end

endmodule // tmh_prescaler

// >>> src/tmh_timer.sv
// 8-bit compare timer channel with axi4-lite registers
// Overview of operation
// - counter equal primary compare raises interrupt in every mode; toggles output unless a secondary match falls in the same tick
// - pwm: secondary compare match toggles output, no interrupt
// - carrier: secondary compare match raises interrupt and clears counter
// - secondary compare written while running is buffered, loaded at next old match
// - cpu write colliding with match transfer cancels that transfer
// - enable low holds counter at zero; high starts at next count clock
// - clock select picks fxx, /2, /4, /16, /64, slowest; others prohibited
// - slowest code: channel 0 uses fxx/1024, channel 1 uses subclock
// - mode field: interval, carrier, pwm; code 11 prohibited
// - default level sets idle output level; output enable gates the pin
// - mode register is byte accessible and resets to zero
// - compare registers are 8 bits, byte accessible, reset to zero
// - interval mode ignores secondary compare entirely
// - interval mode output is a 50 percent square wave
// - carrier status flag is read-only, writes ignored
//
// The AXI4-Lite slave port is this design's own decision.
module tmh_timer #(
  parameter int CHANNEL = 0,
  parameter int ADDR_W  = tmh_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  // axi4-lite write data and response
  input  wire logic [tmh_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0]           s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [tmh_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // timer pins
  input  wire logic                        subClock,
  output logic                             timerOutputPin,
  output logic                             timerMatchIrq
);
  import tmh_pkg::*;

  if (ADDR_W != tmh_pkg::ADDR_W || CHANNEL < 0 || CHANNEL > 1) begin : g_chk
    $error("tmh_timer: ADDR_W must be 28 and CHANNEL 0 or 1");
  end

  logic [1:0]        rstSync_q;
  logic              rstN;
  logic              awHave_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic              wHave_q;
  logic [7:0]        wData_q;
  logic              wLane_q;
  logic              wrFire;
  logic              wrHit;
  logic [7:0]        rdMux;
  logic              rdOk;
  logic [7:0]        timerModeReg_q;
  logic [7:0]        primaryCompare_q;
  logic [7:0]        secondaryBuf_q;
  logic [7:0]        secondaryAct_q;
  logic              reloadPend_q;
  logic [1:0]        carrierCtl_q;
  logic              carrierStatus_q;
  logic              irqStatus_q;
  logic              irqMask_q;
  logic [7:0]        count_q;
  logic              outFf_q;
  logic              wrMode;
  logic              wrCmp0;
  logic              wrCmp1;
  logic              wrCarr;
  logic              wrIrqSt;
  logic              wrIrqMsk;
  logic              enable;
  tmh_mode_t         opMode;
  logic              tick;
  logic              match0;
  logic              match1;
  logic              clearCnt;
  logic              toggleOut;
  logic              matchEvent;

  tmh_tick_if tickIf ();

  // reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end

  assign rstN = rstSync_q[1];

  // write address channel: one address held until the write is done
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      awHave_q      <= 1'b0;
      awAddr_q      <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHave_q      <= 1'b1;
      awAddr_q      <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wrFire || !awHave_q) begin
      awHave_q      <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel; only the low byte lane carries register data
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wHave_q      <= 1'b0;
      wData_q      <= RST_REG;
      wLane_q      <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHave_q      <= 1'b1;
      wData_q      <= s_axi_wdata[7:0];
      wLane_q      <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (wrFire || !wHave_q) begin
      wHave_q      <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // the write lands once both halves are in and no response is pending
  assign wrFire = awHave_q & wHave_q & ~s_axi_bvalid;
  assign wrHit  = (awAddr_q == OFF_MODE)  || (awAddr_q == OFF_CMP0)  ||
                  (awAddr_q == OFF_CMP1)  || (awAddr_q == OFF_CARR)  ||
                  (awAddr_q == OFF_IRQST) || (awAddr_q == OFF_IRQMSK) ||
                  (awAddr_q == OFF_COUNT);

  // write response; unmapped addresses answer slverr and change nothing
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register write strobes
  assign wrMode   = wrFire & wLane_q & (awAddr_q == OFF_MODE);
  assign wrCmp0   = wrFire & wLane_q & (awAddr_q == OFF_CMP0);
  assign wrCmp1   = wrFire & wLane_q & (awAddr_q == OFF_CMP1);
  assign wrCarr   = wrFire & wLane_q & (awAddr_q == OFF_CARR);
  assign wrIrqSt  = wrFire & wLane_q & (awAddr_q == OFF_IRQST);
  assign wrIrqMsk = wrFire & wLane_q & (awAddr_q == OFF_IRQMSK);

  // read mux; narrow registers sit in the low byte
  always_comb begin
    rdOk  = 1'b1;
    rdMux = RST_REG;
    unique case (s_axi_araddr)
      OFF_MODE:   rdMux = timerModeReg_q;
      OFF_CMP0:   rdMux = primaryCompare_q;
      OFF_CMP1:   rdMux = secondaryBuf_q;
      OFF_CARR:   rdMux = {5'h00, carrierCtl_q, carrierStatus_q};
      OFF_IRQST:  rdMux = {7'h00, irqStatus_q};
      OFF_IRQMSK: rdMux = {7'h00, irqMask_q};
      OFF_COUNT:  rdMux = count_q;
      default:    rdOk  = 1'b0;
    endcase
  end

  // read channel: one read outstanding, data registered
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rdMux};
      s_axi_rresp   <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // mode register; software keeps its fields still while running
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      timerModeReg_q <= RST_REG;
    end else if (wrMode) begin
      timerModeReg_q <= wData_q;
    end
  end

  // primary compare: written freely, sampled live by the comparator
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      primaryCompare_q <= RST_REG;
    end else if (wrCmp0) begin
      primaryCompare_q <= wData_q;
    end
  end

  // field decode
  assign enable = timerModeReg_q[MODE_EN];
  assign opMode = tmh_mode_t'(timerModeReg_q[MODE_OPM_H:MODE_OPM_L]);

  // count clock request to the prescaler
  assign tickIf.en       = enable;
  assign tickIf.sel      = timerModeReg_q[MODE_CKS_H:MODE_CKS_L];
  assign tickIf.subClock = subClock;
  // the prohibited mode code stalls the counter rather than guess a behaviour
  assign tick            = tickIf.tick & (opMode != TMH_BADMODE);

  tmh_prescaler #(
    .CHANNEL (CHANNEL)
  ) u_prescaler (
    .clk     (clk),
    .rstN    (rstN),
    .tickIf  (tickIf.prescaler)
  );

  // compare matches; secondary ignored in interval mode
  assign match0     = tick & (count_q == primaryCompare_q);
  assign match1     = tick & ((opMode == TMH_PWM) || (opMode == TMH_CARRIER)) &
                      (count_q == secondaryAct_q);
  assign clearCnt   = match0 | (match1 & (opMode == TMH_CARRIER));
  assign matchEvent = match0 | (match1 & (opMode == TMH_CARRIER));
  // both matches in one tick cancel, keeping the wave edges consistent
  assign toggleOut  = match0 ^ match1;

  // 8-bit counter, natural wrap when nothing clears it
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      count_q <= CNT_CLEAR;
    end else if (!enable) begin
      count_q <= CNT_CLEAR;
    end else if (tick) begin
      count_q <= clearCnt ? CNT_CLEAR : count_q + 8'h01;
    end
  end

  // secondary compare buffer and match-time transfer
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      secondaryBuf_q <= RST_REG;
      secondaryAct_q <= RST_REG;
      reloadPend_q   <= 1'b0;
    end else if (wrCmp1) begin
      secondaryBuf_q <= wData_q;
      if (!enable) begin
        secondaryAct_q <= wData_q;
        reloadPend_q   <= 1'b0;
      end else begin
        reloadPend_q   <= 1'b1; // and
      end
    end else if (match1 && reloadPend_q) begin
      secondaryAct_q <= secondaryBuf_q;
      reloadPend_q   <= 1'b0;
    end
  end

  // output flip-flop: idle level while stopped, toggles on matches
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      outFf_q <= 1'b0;
    end else if (!enable) begin
      outFf_q <= timerModeReg_q[MODE_LEV];
    end else if (toggleOut) begin
      outFf_q <= ~outFf_q; // and
    end
  end

  // pin gated by output enable; low when disabled
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      timerOutputPin <= 1'b0;
    end else begin
      timerOutputPin <= timerModeReg_q[MODE_OEN] & outFf_q;
    end
  end

  // carrier control bits; the status flag is never written by software
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      carrierCtl_q    <= 2'b00;
      carrierStatus_q <= 1'b0;
    end else begin
      if (wrCarr) begin
        carrierCtl_q <= wData_q[CARR_RMC:CARR_NRZB];
      end
      carrierStatus_q <= enable & (opMode == TMH_CARRIER) &
                         timerModeReg_q[MODE_OEN];
    end
  end

  // sticky match flag, write one to clear; a new match beats the clear
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irqStatus_q <= 1'b0;
    end else begin
      irqStatus_q <= (irqStatus_q & ~(wrIrqSt & wData_q[IRQ_MATCH])) | matchEvent;
    end
  end

  // interrupt mask and level output
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irqMask_q     <= 1'b0;
      timerMatchIrq <= 1'b0;
    end else begin
      if (wrIrqMsk) begin
        irqMask_q <= wData_q[IRQ_MATCH];
      end
      timerMatchIrq <= irqStatus_q & irqMask_q;
    end
  end

endmodule // tmh_timer

// >>> testbench/tmh_timer_checker.sv
// assertion checker bound to the timer channel top
module tmh_timer_checker
  import tmh_pkg::*;
#(
  parameter int ADDR_W = 28
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              arst_n,
  // write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  // read channels
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // pins
  input wire logic              timerOutputPin,
  input wire logic              timerMatchIrq
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [ADDR_W-1:0] wAddr_q;
  logic [7:0]        wByte_q;
  logic [7:0]        shMode_q;
  logic [1:0]        quiet_q;
  logic              wEn_q;
  logic              bPrev_q;
  logic              shMask_q;
  logic              fired;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // a write lands on the edge where its response rises
  assign fired = s_axi_bvalid && !bPrev_q && s_axi_bresp == RESP_OKAY && wEn_q;

  // shadow of mode and mask; quiet counts settle time since the last write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wAddr_q  <= '0;
      wByte_q  <= 8'h00;
      wEn_q    <= 1'b0;
      bPrev_q  <= 1'b0;
      shMode_q <= 8'h00;
      shMask_q <= 1'b0;
      quiet_q  <= 2'h0;
    end else begin
      bPrev_q <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) wAddr_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wByte_q <= s_axi_wdata[7:0];
      if (s_axi_wvalid && s_axi_wready) wEn_q <= s_axi_wstrb[0];
      if (fired && wAddr_q == OFF_MODE) shMode_q <= wByte_q;
      if (fired && wAddr_q == OFF_IRQMSK) shMask_q <= wByte_q[IRQ_MATCH];
      quiet_q <= fired ? 2'h0 : (quiet_q == 2'h3 ? quiet_q : quiet_q + 2'h1);
    end
  end

  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data wider than a byte");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_bvalid_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_pin_gated: assert property (quiet_q == 2'h3 && !shMode_q[MODE_OEN] |-> !timerOutputPin)
    else $error("output pin driven while disabled");
  a_idle_level: assert property (quiet_q == 2'h3 && !shMode_q[MODE_EN] |->
    timerOutputPin == (shMode_q[MODE_LEV] & shMode_q[MODE_OEN]))
    else $error("stopped pin not at default level");
  a_irq_masked: assert property (quiet_q == 2'h3 && !shMask_q |-> !timerMatchIrq)
    else $error("interrupt raised while masked");

  // main scenarios reached
  c_irq: cover property ($rose(timerMatchIrq));
  c_pin: cover property ($rose(timerOutputPin));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule // tmh_timer_checker

bind tmh_timer tmh_timer_checker #(.ADDR_W(ADDR_W)) u_chk (
  .clk(clk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .timerOutputPin(timerOutputPin), .timerMatchIrq(timerMatchIrq)
);

// >>> testbench/tmh_timer_tb.sv
// self-checking bench for the 8-bit compare timer channel
module tmh_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tmh_pkg::*;
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [27:0] awAddr = '0, arAddr = '0;
  logic [31:0] wData = '0, rData, d;
  logic [3:0]  wStrb = '0;
  logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic        arValid = 1'b0, rReady = 1'b0, subClock = 1'b0;
  logic        awReady, wReady, bValid, arReady, rValid, pin, irq;
  logic [1:0]  bResp, rResp;
  logic [7:0]  model[logic [27:0]];
  int          num_errors = 0, tests_run = 0, i1, i2, n0, n1;
  int          divs[6] = '{1, 2, 4, 16, 64, 1024};

  // bench clock; sub clock toggles though channel 0 ignores it
  always #50 clk = ~clk;
  always @(posedge clk) subClock <= ~subClock;

  tmh_timer #(.CHANNEL(0)) uut (
    .clk(clk), .arst_n(arst_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .subClock(subClock), .timerOutputPin(pin), .timerMatchIrq(irq)
  );

  // register map lookup
  function automatic logic mapped(logic [27:0] a);
    return a >= OFF_MODE && a <= OFF_COUNT && a[1:0] == 2'h0;
  endfunction

  // expected read value; carrier status is derived from the mode
  function automatic logic [31:0] mexp(logic [27:0] a);
    logic [7:0] m;
    m = model[OFF_MODE];
    if (!mapped(a))
      return 32'h0;
    if (a == OFF_CARR)
      return {24'h0, model[a][7:1], m[MODE_EN] & (m[3:2] == 2'h1) & m[MODE_OEN]};
    return {24'h0, model[a]};
  endfunction

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // a hung handshake counts as a failure and ends the run
  task automatic hang(input int n);
    if (n >= 5000) begin
      num_errors++;
      test_done();
    end
  endtask

  task automatic wr(input logic [27:0] a, input logic [7:0] v, input logic [3:0] s = 4'h1);
    int n;
    n = 0;
    @(posedge clk);
    awAddr <= a;
    awValid <= 1'b1;
    wData <= {24'h0, v};
    wStrb <= s;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (!bValid && n < 5000);
    hang(n);
    bReady <= 1'b0;
    `CHK("bresp", mapped(a) ? RESP_OKAY : RESP_SLVERR, bResp)
    if (mapped(a) && s[0]) begin
      case (a)
        OFF_CARR:   model[a] = v & 8'h06;
        OFF_IRQST:  model[a] = model[a] & ~(v & 8'h01);
        OFF_IRQMSK: model[a] = v & 8'h01;
        OFF_COUNT:  ;
        default:    model[a] = v;
      endcase
    end
  endtask

  task automatic rdm(input logic [27:0] a);
    int n;
    n = 0;
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arReady) arValid <= 1'b0;
    end while (!rValid && n < 5000);
    hang(n);
    rReady <= 1'b0;
    `CHK("rresp", mapped(a) ? RESP_OKAY : RESP_SLVERR, rResp)
    `CHK("rdata", mexp(a), rData)
  endtask

  // cycles until the output pin next changes
  task automatic edge_gap(output int n);
    logic p;
    p = pin;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pin === p && n < 5000);
    hang(n);
  endtask

  // stop, check sticky status and interrupt, then clear it
  task automatic stop_irq();
    wr(OFF_MODE, model[OFF_MODE] & 8'h7F);
    model[OFF_IRQST] = 8'h01;
    repeat (3) @(posedge clk);
    `CHK("irq", model[OFF_IRQMSK][0], irq)
    rdm(OFF_IRQST);
    rdm(OFF_COUNT);
    wr(OFF_IRQMSK, 8'h01);
    repeat (3) @(posedge clk);
    `CHK("irq unmasked", 1'b1, irq)
    wr(OFF_IRQST, 8'h01);
    repeat (3) @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    rdm(OFF_IRQST);
  endtask

  initial begin
    d = $urandom(32'hE0AF7126);
    for (int a = 0; a < 7; a++) model[OFF_MODE + 28'(4 * a)] = 8'h00;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // reset values, unmapped and read-only places, ignored strobe
    for (int a = 0; a < 8; a++) rdm(OFF_MODE + 28'(4 * a));
    wr(28'hFFFF5A4, 8'hFF);
    wr(OFF_COUNT, 8'h55);
    wr(OFF_CARR, 8'h07);
    wr(OFF_CMP0, 8'h5A, 4'h0);
    for (int a = 0; a < 7; a++) rdm(OFF_MODE + 28'(4 * a));
    wr(OFF_CARR, 8'h00);
    // prohibited mode and clock codes leave the counter at zero; far compare exposes a tick
    wr(OFF_CMP0, 8'hF0);
    for (int a = 0; a < 2; a++) begin
      wr(OFF_MODE, a ? 8'h60 : 8'h0C);
      wr(OFF_MODE, model[OFF_MODE] | 8'h80);
      repeat (20) @(posedge clk);
      rdm(OFF_COUNT);
      wr(OFF_MODE, 8'h00);
    end
    $display("test 1 done: register map");
    // interval mode at every clock select; secondary compare must be ignored
    wr(OFF_IRQMSK, 8'h01);
    for (int s = 0; s < 6; s++) begin
      n0 = $urandom_range(0, 3);
      wr(OFF_MODE, {1'b0, 3'(s), 2'h0, 1'($urandom), 1'b1});
      wr(OFF_CMP0, 8'(n0));
      wr(OFF_CMP1, 8'($urandom_range(0, n0)));
      wr(OFF_MODE, model[OFF_MODE] | 8'h80);
      edge_gap(i1);
      edge_gap(i1);
      edge_gap(i2);
      `CHK("half period", (n0 + 1) * divs[s], i1)
      `CHK("duty", i1, i2)
      stop_irq();
    end
    // masked interrupt stays low while status is set
    wr(OFF_IRQMSK, 8'h00);
    wr(OFF_MODE, 8'h01);
    wr(OFF_CMP0, 8'h04);
    wr(OFF_MODE, 8'h81);
    repeat (40) @(posedge clk);
    stop_irq();
    $display("test 2 done: interval and interrupts");
    // carrier: secondary match clears counter; reload while running
    n1 = $urandom_range(2, 10);
    wr(OFF_MODE, 8'h05);
    wr(OFF_CMP0, 8'hC8);
    wr(OFF_CMP1, 8'(n1));
    wr(OFF_MODE, 8'h85);
    rdm(OFF_CARR);
    edge_gap(i1);
    edge_gap(i1);
    `CHK("carrier gap", n1 + 1, i1)
    n1 = $urandom_range(11, 20);
    wr(OFF_CMP1, 8'(n1));
    rdm(OFF_CMP1);
    repeat (60) @(posedge clk);
    edge_gap(i1);
    edge_gap(i1);
    `CHK("reloaded gap", n1 + 1, i1)
    stop_irq();
    $display("test 3 done: carrier");
    // pwm: both matches toggle, primary clears
    n0 = $urandom_range(20, 40);
    n1 = $urandom_range(3, 15);
    wr(OFF_MODE, 8'h09);
    wr(OFF_CMP0, 8'(n0));
    wr(OFF_CMP1, 8'(n1));
    wr(OFF_MODE, 8'h89);
    edge_gap(i1);
    edge_gap(i1);
    edge_gap(i2);
    `CHK("pwm period", n0 + 1, i1 + i2)
    `CHK("pwm split", (n1 + 1) * (n0 - n1), i1 * i2)
    stop_irq();
    $display("test 4 done: pwm");
    test_done();
  end
endmodule // tmh_timer_tb
